/* File: nmsh_card_model.sv */
// behavioural model of the multi-plane nand card
`timescale 1ns/1ps
`default_nettype none

module nmsh_card_model #(
   parameter logic [7:0] MAKER   = 8'h3c, // arbitrary value
   parameter logic [7:0] DEVCODE = 8'h4d, // arbitrary value
   parameter int         T_RST   = 1000,
   parameter int         T_PROG  = 2000,
   parameter int         T_ERASE = 3000,
   parameter int         T_DUMMY = 300
) (
   input  wire nmsh_pkg::nmsh_pins_s pins,
   input  wire logic [7:0]           busIo,
   input  wire logic [3:0]           failMask,
   output logic [7:0]                devByte,
   output logic                      devOe,
   output logic                      rbLow
);
   import nmsh_pkg::*;
   logic [7:0] mode    = 8'h00; // main-area read at power-up
   logic [7:0] latByte;
   logic [3:0] fails   = '0;
   logic [3:0] planes  = '0;
   logic       busy    = 1'b0;
   logic       inRst   = 1'b0;
   logic       done    = 1'b0;
   logic       latCle, latAle;
   int         tok     = 0;
   int         addrCnt = 0;
   int         idIdx   = 0;

   // busy timer; a newer operation cancels the old one's end
   task automatic go(input int ns, input logic [1:0] kind);
      int my;
      tok++;
      my = tok;
      busy = 1'b1;
      fork
         begin
            #(ns);
            if (my == tok) begin
               busy = 1'b0;
               inRst = 1'b0;
               if (kind == 2'd1 || kind == 2'd2)
                  fails |= failMask & planes;
               if (kind == 2'd2)
                  done = 1'b1;
            end
         end
      join_none
   endtask

   // command decoder
   task automatic take(input logic [7:0] c);
      if (c == 8'hff) begin
         if (!inRst) begin
            mode = 8'h00;
            {fails, planes, done} = '0;
            inRst = 1'b1;
            go(T_RST, 2'd3);
         end
      end else if (!busy || c[7:1] == 7'h38) begin
         case (c)
            8'h80, 8'h60: begin
               if (done)
                  {fails, planes, done} = '0;
               mode = c;
               addrCnt = 0;
            end
            8'h11: go(T_DUMMY, 2'd0);
            8'h10: go(T_PROG, 2'd2);
            8'h15: go(T_PROG, 2'd1);
            8'hd0: go(T_ERASE, 2'd2);
            default: begin
               mode = c;
               idIdx = 0;
            end
         endcase
      end
   endtask

   // latch lines as the write strobe falls, act on its rise
   always @(negedge pins.weN) begin
      {latCle, latAle, latByte} = {pins.cle, pins.ale, busIo};
   end
   always @(posedge pins.weN) begin
      if (pins.ceN === 1'b0 && latCle)
         take(latByte);
      else if (pins.ceN === 1'b0 && latAle && !busy) begin
         addrCnt++;
         if (addrCnt == ((mode == 8'h60) ? 1 : 2))
            planes[latByte[6:5]] = 1'b1;
      end
   end
   always @(posedge pins.readStrobeN) begin
      if (mode[7:1] == 7'h48)
         idIdx++;
   end

   // output byte follows state while selected and strobed
   always @* begin
      devOe = pins.ceN === 1'b0 && pins.readStrobeN === 1'b0
         && (mode[7:1] == 7'h38 || mode[7:1] == 7'h48);
      if (mode[7:1] == 7'h38)
         devByte = {pins.wpN, !busy, 1'b0, busy ? 5'h15
            : {(mode[0] ? fails : 4'ha), |fails}};
      else
         devByte = mode[0] ? 8'h20 : ((idIdx == 0) ? MAKER : DEVCODE);
   end
   assign rbLow = busy;
endmodule
`default_nettype wire

/* File: nmsh_cfg.svh */
// constants of the nand multi-plane host controller
`ifndef NMSH_CFG_SVH
`define NMSH_CFG_SVH

// =====================================
// register offsets (byte addresses)
`define NMSH_OFS_CTRL     8'h00
`define NMSH_OFS_STATUS   8'h04
`define NMSH_OFS_CONFIG   8'h08

// =====================================
// ctrl fields
`define NMSH_CTRL_OP_LSB    0
`define NMSH_CTRL_BYTE_LSB  8

// status fields
`define NMSH_ST_BUSY        0
`define NMSH_ST_READY       1
`define NMSH_ST_STMODE      2
`define NMSH_ST_RDBYTE_LSB  8
`define NMSH_ST_STAT_LSB    16

// config fields and reset value
`define NMSH_CFG_SELECT     0
`define NMSH_CFG_WPOFF      1
`define NMSH_CFG_MULTI      2
`define NMSH_CONFIG_RST     3'h0

// =====================================
// device commands
`define NMSH_CMD_STATUS     8'h70
`define NMSH_CMD_MSTATUS    8'h71
`define NMSH_CMD_RESET      8'hff
`define NMSH_STAT_RDY_BIT   6
`define NMSH_STAT_RST       8'hc0

// =====================================
// timing
`define NMSH_CLK_MHZ        200
`define NMSH_STROBE_NS      30
`define NMSH_STROBE_CYC     ((`NMSH_STROBE_NS*`NMSH_CLK_MHZ+999)/1000)
`define NMSH_TWB_NS         100
`define NMSH_TWB_CYC        ((`NMSH_TWB_NS*`NMSH_CLK_MHZ+999)/1000)

// axi responses
`define NMSH_RESP_OKAY      2'h0
`define NMSH_RESP_SLVERR    2'h2

`endif

/* File: nmsh_host.sv */
// host controller for the nand card: axi4-lite slave and pin engine
`timescale 1ns/1ps
`default_nettype none
`include "nmsh_cfg.svh"

module nmsh_host (
   input  wire logic                ref_clk,
   input  wire logic                rst,
   input  wire logic [7:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [7:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   output nmsh_pkg::nmsh_pins_s     pins,
   input  wire logic [7:0]          ioIn,
   output logic [7:0]               ioOut,
   output logic                     ioOe,
   input  wire logic                readyBusyIn
);
   import nmsh_pkg::*;

   localparam logic [7:0] STROBE = 8'(`NMSH_STROBE_CYC);
   localparam logic [7:0] TWB    = 8'(`NMSH_TWB_CYC);

   // =====================================
   // pin input synchronisers
   logic [8:0] syncOut;
   logic [7:0] ioSync;
   logic       rbSync;

   nmsh_sync #(.W(9)) u_sync (
      .ref_clk (ref_clk),
      .rst     (rst),
      .din     ({readyBusyIn, ioIn}),
      .dout    (syncOut)
   );
   assign ioSync = syncOut[7:0];
   assign rbSync = syncOut[8];

   // =====================================
   // axi4-lite slave state
   logic        awHave_r, awHave_nxt, wHave_r, wHave_nxt;
   logic [7:0]  awAddr_r, awAddr_nxt;
   logic [31:0] wData_r, wData_nxt;
   logic [3:0]  wStrb_r, wStrb_nxt;
   logic        bValid_r, bValid_nxt, rValid_r, rValid_nxt;
   logic [1:0]  bResp_r, bResp_nxt, rResp_r, rResp_nxt;
   logic [31:0] rData_r, rData_nxt;
   logic [2:0]  config_r, config_nxt;
   logic        start;
   logic [2:0]  startOp;
   logic [7:0]  startByte;

   // engine state
   nmsh_state_e st_r, st_nxt;
   nmsh_op_e    op_r, op_nxt;
   logic [7:0]  cnt_r, cnt_nxt, byte_r, byte_nxt;
   logic [7:0]  rdByte_r, rdByte_nxt, stat_r, stat_nxt;
   logic        stMode_r, stMode_nxt;
   nmsh_pins_s  pins_r, pins_nxt;
   logic [7:0]  ioOut_r, ioOut_nxt;
   logic        ioOe_r, ioOe_nxt;
   logic        engBusy;

   assign engBusy = (st_r != ST_IDLE);

   // =====================================
   // axi next values: aw and w in either order, response after both
   always_comb begin
      awHave_nxt = awHave_r;
      awAddr_nxt = awAddr_r;
      wHave_nxt  = wHave_r;
      wData_nxt  = wData_r;
      wStrb_nxt  = wStrb_r;
      bValid_nxt = bValid_r;
      bResp_nxt  = bResp_r;
      rValid_nxt = rValid_r;
      rResp_nxt  = rResp_r;
      rData_nxt  = rData_r;
      config_nxt = config_r;
      start      = 1'b0;
      startOp    = wData_r[`NMSH_CTRL_OP_LSB +: 3];
      startByte  = wData_r[`NMSH_CTRL_BYTE_LSB +: 8];
      if (s_axi_awvalid && !awHave_r) begin
         awHave_nxt = 1'b1;
         awAddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHave_r) begin
         wHave_nxt = 1'b1;
         wData_nxt = s_axi_wdata;
         wStrb_nxt = s_axi_wstrb;
      end
      if (awHave_r && wHave_r && !bValid_r) begin
         awHave_nxt = 1'b0;
         wHave_nxt  = 1'b0;
         bValid_nxt = 1'b1;
         bResp_nxt  = `NMSH_RESP_OKAY;
         unique case (awAddr_r)
            `NMSH_OFS_CTRL: begin
               // no new order while busy: reset is not repeated
               if (engBusy || startOp > 3'd6 || !(&wStrb_r[1:0]))
                  bResp_nxt = `NMSH_RESP_SLVERR;
               else
                  start = 1'b1;
            end
            `NMSH_OFS_CONFIG: begin
               if (wStrb_r[0])
                  config_nxt = wData_r[2:0];
            end
            default: bResp_nxt = `NMSH_RESP_SLVERR;
         endcase
      end
      if (bValid_r && s_axi_bready)
         bValid_nxt = 1'b0;
      if (s_axi_arvalid && !rValid_r) begin
         rValid_nxt = 1'b1;
         rResp_nxt  = `NMSH_RESP_OKAY;
         rData_nxt  = 32'h0;
         unique case (s_axi_araddr)
            `NMSH_OFS_CTRL:   rData_nxt = {24'h0, 5'h0, op_r};
            `NMSH_OFS_STATUS: begin
               rData_nxt[`NMSH_ST_BUSY]            = engBusy;
               rData_nxt[`NMSH_ST_READY]           = rbSync;
               rData_nxt[`NMSH_ST_STMODE]          = stMode_r;
               rData_nxt[`NMSH_ST_RDBYTE_LSB +: 8] = rdByte_r;
               rData_nxt[`NMSH_ST_STAT_LSB +: 8]   = stat_r;
            end
            `NMSH_OFS_CONFIG: rData_nxt = {29'h0, config_r};
            default:          rResp_nxt = `NMSH_RESP_SLVERR;
         endcase
      end else if (rValid_r && s_axi_rready) begin
         rValid_nxt = 1'b0;
      end
   end

   // axi registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         awHave_r <= 1'b0;
         awAddr_r <= 8'h00;
         wHave_r  <= 1'b0;
         wData_r  <= 32'h0;
         wStrb_r  <= 4'h0;
         bValid_r <= 1'b0;
         bResp_r  <= `NMSH_RESP_OKAY;
         rValid_r <= 1'b0;
         rResp_r  <= `NMSH_RESP_OKAY;
         rData_r  <= 32'h0;
         config_r <= `NMSH_CONFIG_RST;
      end else begin
         awHave_r <= awHave_nxt;
         awAddr_r <= awAddr_nxt;
         wHave_r  <= wHave_nxt;
         wData_r  <= wData_nxt;
         wStrb_r  <= wStrb_nxt;
         bValid_r <= bValid_nxt;
         bResp_r  <= bResp_nxt;
         rValid_r <= rValid_nxt;
         rResp_r  <= rResp_nxt;
         rData_r  <= rData_nxt;
         config_r <= config_nxt;
      end
   end

   // =====================================
   // pin engine next values
   always_comb begin
      st_nxt     = st_r;
      op_nxt     = op_r;
      cnt_nxt    = cnt_r;
      byte_nxt   = byte_r;
      rdByte_nxt = rdByte_r;
      stat_nxt   = stat_r;
      stMode_nxt = stMode_r;
      pins_nxt   = pins_r;
      ioOut_nxt  = ioOut_r;
      ioOe_nxt   = ioOe_r;
      pins_nxt.ceN = ~config_r[`NMSH_CFG_SELECT];
      pins_nxt.wpN = config_r[`NMSH_CFG_WPOFF];
      unique case (st_r)
         ST_IDLE: begin
            if (start) begin
               op_nxt    = nmsh_op_e'(startOp);
               byte_nxt  = startByte;
               cnt_nxt   = STROBE;
               st_nxt    = ST_SETUP;
               unique case (nmsh_op_e'(startOp))
                  OP_STATUS: byte_nxt = config_r[`NMSH_CFG_MULTI] ?
                        `NMSH_CMD_MSTATUS : `NMSH_CMD_STATUS;
                  OP_RESET:  byte_nxt = `NMSH_CMD_RESET;
                  OP_WAIT: begin
                     cnt_nxt = TWB;
                     st_nxt  = ST_WB; // dummy-program busy wait
                  end
                  default: ;
               endcase
            end
         end
         ST_SETUP: begin
            // command for cmd, status, reset; address with software page
            // bits kept equal across planes
            pins_nxt.cle = (op_r == OP_CMD) || (op_r == OP_STATUS) ||
                           (op_r == OP_RESET);
            pins_nxt.ale = (op_r == OP_ADDR);
            ioOut_nxt    = byte_r;
            ioOe_nxt     = (op_r != OP_READ); // never drive on reads
            if (pins_nxt.cle)
               stMode_nxt = (op_r == OP_STATUS);
            cnt_nxt = cnt_r - 8'h01;
            if (cnt_r == 8'h01) begin
               cnt_nxt = STROBE;
               st_nxt  = ST_LOW;
            end
         end
         ST_LOW: begin
            pins_nxt.weN         = (op_r == OP_READ);
            pins_nxt.readStrobeN = (op_r != OP_READ);
            cnt_nxt = cnt_r - 8'h01;
            if (cnt_r == 8'h01) begin
               if (op_r == OP_READ)
                  rdByte_nxt = ioSync; // id and data bytes
               cnt_nxt = STROBE;
               st_nxt  = ST_HIGH;
            end
         end
         ST_HIGH: begin
            pins_nxt.weN         = 1'b1;
            pins_nxt.readStrobeN = 1'b1;
            pins_nxt.cle         = 1'b0;
            pins_nxt.ale         = 1'b0;
            ioOe_nxt             = 1'b0;
            cnt_nxt = cnt_r - 8'h01;
            if (cnt_r == 8'h01) begin
               cnt_nxt = STROBE;
               unique case (op_r)
                  OP_STATUS: begin
                     // strobe falls now so the first poll is a full width
                     pins_nxt.readStrobeN = 1'b0;
                     st_nxt               = ST_POLL;
                  end
                  OP_RESET: begin
                     cnt_nxt = TWB;
                     st_nxt  = ST_WB; // reset busy follows
                  end
                  default:   st_nxt = ST_IDLE;
               endcase
            end
         end
         ST_POLL: begin
            // strobe held low, device refreshes the byte
            pins_nxt.readStrobeN = 1'b0;
            cnt_nxt = cnt_r - 8'h01;
            if (cnt_r == 8'h01) begin
               cnt_nxt = STROBE;
               if (ioSync[`NMSH_STAT_RDY_BIT] && rbSync) begin
                  // result bits kept only once ready
                  stat_nxt             = ioSync;
                  pins_nxt.readStrobeN = 1'b1;
                  st_nxt               = ST_IDLE;
               end
            end
         end
         ST_WB: begin
            cnt_nxt = cnt_r - 8'h01;
            if (cnt_r == 8'h01)
               st_nxt = ST_RB;
         end
         ST_RB: begin
            if (rbSync) begin
               if (op_r == OP_RESET)
                  stat_nxt = `NMSH_STAT_RST;
               st_nxt = ST_IDLE;
            end
         end
         default: st_nxt = ST_IDLE;
      endcase
   end

   // engine registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_r     <= ST_IDLE;
         op_r     <= OP_CMD;
         cnt_r    <= 8'h00;
         byte_r   <= 8'h00;
         rdByte_r <= 8'h00;
         stat_r   <= 8'h00;
         stMode_r <= 1'b0;
         pins_r   <= '{ceN: 1'b1, cle: 1'b0, ale: 1'b0, weN: 1'b1,
                       readStrobeN: 1'b1, wpN: 1'b0};
         ioOut_r  <= 8'h00;
         ioOe_r   <= 1'b0;
      end else begin
         st_r     <= st_nxt;
         op_r     <= op_nxt;
         cnt_r    <= cnt_nxt;
         byte_r   <= byte_nxt;
         rdByte_r <= rdByte_nxt;
         stat_r   <= stat_nxt;
         stMode_r <= stMode_nxt;
         pins_r   <= pins_nxt;
         ioOut_r  <= ioOut_nxt;
         ioOe_r   <= ioOe_nxt;
      end
   end

   // =====================================
   // outputs straight from flops
   assign s_axi_awready = ~awHave_r;
   assign s_axi_wready  = ~wHave_r;
   assign s_axi_bvalid  = bValid_r;
   assign s_axi_bresp   = bResp_r;
   assign s_axi_arready = ~rValid_r;
   assign s_axi_rvalid  = rValid_r;
   assign s_axi_rresp   = rResp_r;
   assign s_axi_rdata   = rData_r;
   assign pins          = pins_r;
   assign ioOut         = ioOut_r;
   assign ioOe          = ioOe_r;

endmodule

`default_nettype wire

/* File: nmsh_host_props.sv */
// port checks of the nand host controller
`timescale 1ns/1ps
`default_nettype none

module nmsh_host_props (
   input wire logic                 ref_clk,
   input wire logic                 rst,
   input wire logic                 s_axi_awvalid,
   input wire logic                 s_axi_awready,
   input wire logic                 s_axi_wvalid,
   input wire logic                 s_axi_wready,
   input wire logic                 s_axi_bvalid,
   input wire logic                 s_axi_bready,
   input wire logic [1:0]           s_axi_bresp,
   input wire logic                 s_axi_arvalid,
   input wire logic                 s_axi_arready,
   input wire logic                 s_axi_rvalid,
   input wire logic                 s_axi_rready,
   input wire logic [31:0]          s_axi_rdata,
   input wire nmsh_pkg::nmsh_pins_s pins,
   input wire logic [7:0]           ioOut,
   input wire logic                 ioOe
);
   import nmsh_pkg::*;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   // ==========================================
   // register bus handshakes
   aw_hold_a: assert property (s_axi_awvalid && s_axi_awready
      |=> !s_axi_awready) else $error("address not held");
   w_resp_a: assert property (s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   r_resp_a: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid && !s_axi_arready) else $error("read late");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");

   // ==========================================
   // card pins
   we_width_a: assert property ($fell(pins.weN)
      |-> !pins.weN [*6] ##1 pins.weN) else $error("write strobe width");
   read_width_a: assert property ($fell(pins.readStrobeN)
      |-> !pins.readStrobeN [*6]) else $error("read strobe width");
   bus_turn_a: assert property (!pins.readStrobeN |-> !ioOe)
      else $error("host drives bus during read");
   setup_a: assert property ($fell(pins.weN) |-> ioOe
      && $stable(ioOut) && !(pins.cle && pins.ale))
      else $error("command or address not set up");

   // main scenarios
   cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
   cover property ($fell(pins.readStrobeN) ##7 !pins.readStrobeN);
   cover property ($rose(pins.cle) && ioOut == 8'hd0);
endmodule

bind nmsh_host nmsh_host_props nmsh_host_props_i (
   .ref_clk(ref_clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata), .pins(pins), .ioOut(ioOut), .ioOe(ioOe)
);
`default_nettype wire

/* File: nmsh_pkg.sv */
// types of the nand multi-plane host controller
`default_nettype none
package nmsh_pkg;

   // =====================================
   // operations that software may start
   typedef enum logic [2:0] {
      OP_CMD, OP_ADDR, OP_WRITE, OP_READ, OP_WAIT, OP_STATUS, OP_RESET
   } nmsh_op_e;

   // engine states
   typedef enum logic [2:0] {
      ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH, ST_POLL, ST_WB, ST_RB
   } nmsh_state_e;

   // control pins of the card, all driven by the host
   typedef struct packed {
      logic ceN;
      logic cle;
      logic ale;
      logic weN;
      logic readStrobeN;
      logic wpN;
   } nmsh_pins_s;

endpackage

`default_nettype wire

/* File: nmsh_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module nmsh_sync #(
   parameter int W = 1
) (
   input  wire logic         ref_clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);

   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] dout_nxt;

   // =====================================
   // next values: shift by one stage
   always_comb begin
      meta_nxt = din;
      dout_nxt = meta_r;
   end

   // registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         meta_r <= '0;
         dout   <= '0;
      end else begin
         meta_r <= meta_nxt;
         dout   <= dout_nxt;
      end
   end

endmodule

`default_nettype wire

/* File: nmsh_tb.sv */
// self-checking bench of the nand host controller with a card model
`timescale 1ns/1ps
`default_nettype none
`include "nmsh_cfg.svh"

module tb;
   import nmsh_pkg::*;
   localparam logic [7:0] MAKER   = 8'h3c; // arbitrary value
   localparam logic [7:0] DEVCODE = 8'h4d; // arbitrary value
   logic        ref_clk, rst, awValid, awReady, wValid, wReady, bValid;
   logic        bReady, arValid, arReady, rValid, rReady, ioOe, devOe;
   logic        rbLow;
   logic [7:0]  awAddr, arAddr, ioOut, ioIn, devByte, floatByte;
   logic [31:0] wData, rData;
   logic [1:0]  bResp, rResp;
   logic [3:0]  failMask;
   nmsh_pins_s  pins;
   int          nErrors, checksDone;

   // wired bus: host, card, or a changing float pattern
   assign ioIn = ioOe ? ioOut : (devOe ? devByte : floatByte);

   nmsh_host nmsh_host_i (
      .ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awAddr),
      .s_axi_awvalid(awValid), .s_axi_awready(awReady),
      .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid),
      .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
      .s_axi_bready(bReady), .s_axi_araddr(arAddr),
      .s_axi_arvalid(arValid), .s_axi_arready(arReady),
      .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
      .s_axi_rready(rReady), .pins(pins), .ioIn(ioIn), .ioOut(ioOut),
      .ioOe(ioOe), .readyBusyIn(!rbLow) // pulled-up line
   );
   nmsh_card_model #(.MAKER(MAKER), .DEVCODE(DEVCODE)) nmsh_card_model_i (
      .pins(pins), .busIo(ioIn), .failMask(failMask), .devByte(devByte),
      .devOe(devOe), .rbLow(rbLow)
   );

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) floatByte <= ~floatByte;

   // ==========================================
   // helpers
   task automatic reportAndStop;
      $display("checks %0d mismatches %0d", checksDone, nErrors);
      if (nErrors == 0 && checksDone > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checksDone++;
      if (seen !== exp) begin
         nErrors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      bit ad, wd;
      {ad, wd} = 2'b00;
      awAddr <= a;
      wData <= d;
      {awValid, wValid, bReady} <= 3'b111;
      while (!(ad && wd)) begin
         @(posedge ref_clk);
         if (awReady && !ad) begin
            ad = 1;
            awValid <= 1'b0;
         end
         if (wReady && !wd) begin
            wd = 1;
            wValid <= 1'b0;
         end
      end
      do @(posedge ref_clk); while (!bValid);
      r = bResp;
      bReady <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rdSt(output logic [31:0] d);
      arAddr <= `NMSH_OFS_STATUS;
      {arValid, rReady} <= 2'b11;
      do @(posedge ref_clk); while (!arReady);
      arValid <= 1'b0;
      do @(posedge ref_clk); while (!rValid);
      d = rData;
      chk("read response", rResp, `NMSH_RESP_OKAY);
      rReady <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic op(input nmsh_op_e o, input logic [7:0] b);
      logic [31:0] s;
      logic [1:0]  r;
      wr(`NMSH_OFS_CTRL, {16'h0, b, 5'h0, o}, r);
      do rdSt(s); while (s[`NMSH_ST_BUSY]);
   endtask
   task automatic readByte(output logic [7:0] b);
      logic [31:0] s;
      op(OP_READ, 8'h00);
      rdSt(s);
      b = s[15:8];
   endtask
   task automatic prog(input logic [1:0] p, input logic [7:0] conf);
      op(OP_CMD, 8'h80);
      op(OP_ADDR, 8'h00);
      op(OP_ADDR, {1'b0, p, 5'h02}); // same low page bits
      op(OP_ADDR, 8'h00);
      op(OP_ADDR, 8'h00);
      op(OP_WRITE, 8'ha5);
      op(OP_CMD, conf);
   endtask

   // ==========================================
   // scenarios
   task automatic test_reset;
      logic [31:0] s;
      logic [1:0]  r;
      bit          sawBusy;
      sawBusy = 0;
      wr(8'h0c, 32'h0, r);
      chk("unmapped write", r, `NMSH_RESP_SLVERR);
      wr(`NMSH_OFS_CONFIG, 32'h7, r); // multi-plane status
      wr(`NMSH_OFS_CTRL, {24'h0, 5'h0, OP_RESET}, r);
      do begin
         rdSt(s);
         if (!s[`NMSH_ST_READY])
            sawBusy = 1;
      end while (s[`NMSH_ST_BUSY]);
      chk("ready low in reset", sawBusy, 1'b1);
      op(OP_STATUS, 8'h00);
      rdSt(s);
      chk("status after reset", s[23:16], `NMSH_STAT_RST);
      $display("test_reset done");
   endtask
   task automatic test_id;
      logic [7:0] b;
      op(OP_CMD, 8'h90);
      op(OP_ADDR, 8'h00);
      readByte(b);
      chk("id first", b, MAKER);
      readByte(b);
      chk("id second", b, DEVCODE);
      op(OP_CMD, 8'h91);
      op(OP_ADDR, 8'h00);
      readByte(b);
      chk("id capability", b, 8'h20);
      $display("test_id done");
   endtask
   task automatic test_erase;
      logic [31:0] s;
      failMask = 4'b0100;
      for (int i = 2; i >= 0; i -= 2) begin
         op(OP_CMD, 8'h60);
         op(OP_ADDR, {1'b0, i[1:0], 5'h00});
         op(OP_ADDR, 8'h00);
         op(OP_ADDR, 8'h00);
      end
      op(OP_CMD, 8'hd0);
      rdSt(s);
      chk("busy on erase", s[`NMSH_ST_READY], 1'b0);
      op(OP_STATUS, 8'h00); // polls until ready
      rdSt(s);
      chk("erase status", s[23:16], 8'hc9);
      chk("status mode", s[`NMSH_ST_STMODE], 1'b1);
      $display("test_erase done");
   endtask
   task automatic test_program;
      logic [31:0] s;
      logic [7:0]  b;
      failMask = 4'b1000;
      prog(2'd1, 8'h11);
      op(OP_WAIT, 8'h00);
      prog(2'd3, 8'h15);
      op(OP_WAIT, 8'h00);
      failMask = 4'b0000;
      prog(2'd0, 8'h10); // normal confirm ends the set
      op(OP_CMD, 8'h70);
      op(OP_CMD, 8'h90);
      readByte(b);
      chk("status while busy", b & 8'hc0, 8'h80);
      op(OP_STATUS, 8'h00);
      rdSt(s);
      chk("cached fail kept", s[23:16], 8'hd1);
      $display("test_program done");
   endtask
   task automatic test_abort;
      logic [31:0] s;
      failMask = 4'b1111;
      op(OP_CMD, 8'h60);
      op(OP_ADDR, 8'h20);
      op(OP_ADDR, 8'h00);
      op(OP_ADDR, 8'h00);
      op(OP_CMD, 8'hd0);
      op(OP_RESET, 8'h00);
      op(OP_STATUS, 8'h00);
      rdSt(s);
      chk("erase aborted", s[23:16], 8'hc0);
      $display("test_abort done");
   endtask

   initial begin
      repeat (40000) @(posedge ref_clk);
      nErrors++;
      reportAndStop;
   end
   initial begin
      {rst, awValid, wValid, bReady, arValid, rReady} = 6'h20;
      {awAddr, arAddr, wData, failMask} = '0;
      floatByte = 8'h5a;
      nErrors = 0;
      checksDone = 0;
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      test_reset;
      test_id;
      test_erase;
      test_program;
      test_abort;
      reportAndStop;
   end
endmodule
`default_nettype wire
